// ### shared/fspc_pkg.sv
`default_nettype none
package fspc_pkg;
   // apb register map
   localparam logic [11:0] FSPC_CSR_OFF = 12'h000;   // control/status
   localparam logic [11:0] FSPC_PTR_OFF = 12'h004;   // pointer register
   localparam logic [11:0] FSPC_DATA_OFF = 12'h008;  // r1:r0 word
   localparam logic [11:0] FSPC_CFG_OFF = 12'h00C;   // fuse/variant/core
   localparam logic [11:0] FSPC_STAT_OFF = 12'h010;  // decoded regions
   localparam logic [11:0] FSPC_RDAT_OFF = 12'h014;  // last load result
   localparam logic [11:0] FSPC_OP_OFF = 12'h018;    // word index and word address
   // control/status bit positions
   localparam int FSPC_IRQEN_BIT = 7;
   localparam int FSPC_BUSY_BIT = 6;
   localparam int FSPC_SIG_BIT = 5;
   localparam int FSPC_REEN_BIT = 4;
   localparam int FSPC_WRT_BIT = 2;
   localparam int FSPC_ERS_BIT = 1;
   localparam int FSPC_EN_BIT = 0;
   localparam logic [7:0] FSPC_CSR_RST = 8'h00;
   // accepted low-five-bit command patterns
   // signature read carries only the enable in the low five bits
   localparam logic [4:0] FSPC_CMD_SIG = 5'h01;
   localparam logic [4:0] FSPC_CMD_REEN = 5'h11;
   localparam logic [4:0] FSPC_CMD_WRT = 5'h05;
   localparam logic [4:0] FSPC_CMD_ERS = 5'h03;
   localparam logic [4:0] FSPC_CMD_FILL = 5'h01;
   // windows in cycles
   localparam int FSPC_STORE_WIN = 4;
   localparam int FSPC_LOAD_WIN = 3;
   // page geometry
   localparam int FSPC_PAGE_WORDS = 128;
   localparam int FSPC_IDX_W = 7;
   localparam int FSPC_HALTING_WRITE_REGION_PAGES = 32;
   localparam int FSPC_RWW_PAGES = 224;
   // programming time
   localparam int FSPC_PROG_US = 4500;
   localparam int FSPC_CLK_MHZ = 100;
   localparam int FSPC_PROG_CYC = FSPC_PROG_US * FSPC_CLK_MHZ;
   // last store operation code
   typedef enum logic [2:0] {FSPC_OP_NONE, FSPC_OP_FILL, FSPC_OP_ERASE,
      FSPC_OP_WRITE, FSPC_OP_REEN, FSPC_OP_NOP} fspc_op_t;
endpackage
`default_nettype wire

// ### rtl/fspc_region_map.sv
`default_nettype none
// boot-size fuse and pointer decode, purely combinational
module fspc_region_map
   import fspc_pkg::*;
#(
   parameter int PC_W = 15
)
(
   input wire logic [1:0] boot_size,
   input wire logic [15:0] pointer,
   output logic [14:0] boot_start,
   output logic [14:0] app_end,
   output logic [14:0] word_addr,
   output logic [7:0] page_num,
   output logic [6:0] word_idx,
   output logic in_rww
);
   localparam logic [14:0] TOP = 15'((1 << PC_W) - 1);
   logic [12:0] boot_words;   // boot region size in words
   initial
   begin
      if (PC_W != 14 && PC_W != 15)
         $error("fspc_region_map: PC_W must be 14 or 15");
   end
   // fuse decode, size doubles per step down
   always_comb
   begin
      case (boot_size)
         2'b11: boot_words = 13'(PC_W == 15 ? 512 : 256);  // RULE_01 RULE_02
         2'b10: boot_words = 13'(PC_W == 15 ? 1024 : 512);
         2'b01: boot_words = 13'(PC_W == 15 ? 2048 : 1024);
         default: boot_words = 13'(PC_W == 15 ? 4096 : 2048);
      endcase
   end
   assign boot_start = TOP - 15'(boot_words) + 15'h0001;  // RULE_01 RULE_02
   assign app_end = boot_start - 15'h0001;
   // word address is pointer shifted down one, masked to PC_W bits
   assign word_addr = pointer[15:1] & TOP;  // RULE_04 RULE_06
   assign word_idx = pointer[7:1];  // RULE_05 RULE_08
   assign page_num = (PC_W == 15) ? pointer[15:8]
                                  : {1'b0, pointer[14:8]};  // RULE_07
   // rww region ends where the largest boot region starts
   assign in_rww = page_num < 8'(PC_W == 15 ? FSPC_RWW_PAGES
                                            : FSPC_RWW_PAGES / 2);  // RULE_03
endmodule
`default_nettype wire

// ### rtl/fspc_ctrl.sv
`default_nettype none
// What this block does
// (RULE_01) 32K fuse decodes 256..2048-word boot region
// (RULE_02) 64K fuse decodes 512..4096-word boot region
// (RULE_03) lower 224 pages readable, top 32 not
// (RULE_04) 14-bit or 15-bit word counter
// (RULE_05) 128-word pages, seven-bit word index
// (RULE_06) pointer bit n+1 carries address bit n
// (RULE_07) page number from upper pointer bits
// (RULE_08) buffer word from pointer bits above zero
// (RULE_09) core zeroes word index on page write
// (RULE_10) core keeps pointer bit zero clear
// (RULE_11) pointer bit zero picks load byte
// (RULE_12) ready irq while enabled and idle
// (RULE_13) busy flag set on rww erase/write
// (RULE_14) busy flag blocks rww region access
// (RULE_15) reenable after completion clears busy
// (RULE_16) buffer fill start clears busy
// (RULE_17) signature read window three cycles
// (RULE_18) store while signature armed records nop, buffer fill still runs
// (RULE_19) software avoids signature read
// (RULE_20) enable arms store for four cycles
// (RULE_21) reenable only when flash idle
// (RULE_22) command bits auto-clear; halt for halting_write_region
// (RULE_23) undefined command patterns ignored
// (RULE_24) signature bit clears when window closes
module fspc_ctrl
   import fspc_pkg::*;
#(
   parameter int PC_W = 15,
   parameter int PROG_CYC = FSPC_PROG_CYC
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic global_irq_en,
   input wire logic [15:0] flash_word,
   output logic store_ready_irq,
   output logic core_halt,
   output logic rww_blocked,
   output logic flash_busy
);
   import fspc_pkg::*;

   // refuse a programming time the countdown cannot serve
   initial
   begin
      if (PROG_CYC < 2)
         $error("fspc_ctrl: PROG_CYC too small");
   end

   // internal state
   logic [7:0] csr_q;            // control/status
   logic [15:0] ptr_q;           // pointer register
   logic [15:0] data_q;          // r1:r0 word
   logic [1:0] boot_size_q;      // boot-size fuse
   logic [7:0] rdat_q;           // last load byte
   fspc_op_t op_q;               // last store action
   logic [2:0] win_q;            // arm window countdown
   logic [2:0] sig_win_q;        // signature load window
   logic [31:0] prog_q;          // programming countdown
   logic prog_halting_write_region_q;            // current op aims at halting_write_region
   logic [7:0] tmp_buf [FSPC_PAGE_WORDS*2];  // page buffer bytes
   // decoded regions and pointer fields
   logic [14:0] boot_start, app_end, word_addr;
   logic [7:0] page_num;
   logic [6:0] word_idx;
   logic in_rww;
   // bus strobes and core instruction events
   logic wr, rd, csr_wr, cfg_wr, store_go, load_go, prog_active;
   logic cmd_ok;
   logic [31:0] rd_d;

   // fuse and pointer decode
   fspc_region_map #(.PC_W(PC_W)) u_map (
      .boot_size(boot_size_q),
      .pointer(ptr_q),
      .boot_start(boot_start),
      .app_end(app_end),
      .word_addr(word_addr),
      .page_num(page_num),
      .word_idx(word_idx),
      .in_rww(in_rww)
   );

   // apb strobes, zero-wait access phase
   assign wr = psel && penable && pwrite && clk_en;
   assign rd = psel && penable && !pwrite && clk_en;
   assign csr_wr = wr && paddr == FSPC_CSR_OFF;
   assign cfg_wr = wr && paddr == FSPC_CFG_OFF;
   assign prog_active = prog_q != 32'h0;
   // store instruction from core, bit 8 of cfg write
   assign store_go = cfg_wr && pwdata[8];
   // load instruction from core, bit 9 of cfg write
   assign load_go = cfg_wr && pwdata[9];
   // only the defined low-five patterns take effect
   always_comb
   begin
      case (pwdata[4:0])
         FSPC_CMD_REEN, FSPC_CMD_WRT, FSPC_CMD_ERS,
         FSPC_CMD_FILL: cmd_ok = 1'b1;  // RULE_23
         default: cmd_ok = 1'b0;
      endcase
   end

   // control/status and window handling
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         csr_q <= FSPC_CSR_RST;
         win_q <= 3'h0;
         sig_win_q <= 3'h0;
         prog_q <= 32'h0;
         prog_halting_write_region_q <= 1'b0;
         op_q <= FSPC_OP_NONE;
      end
      else if (clk_en)
      begin
         // window countdowns
         if (win_q != 3'h0)
            win_q <= win_q - 3'h1;
         if (sig_win_q != 3'h0)
            sig_win_q <= sig_win_q - 3'h1;
         else
            csr_q[FSPC_SIG_BIT] <= 1'b0;  // RULE_24
         // arm window expired with no store
         if (win_q == 3'h1 && !store_go && !prog_active)
            csr_q[4:0] <= 5'h00;  // RULE_20 RULE_22
         // programming completion
         if (prog_q == 32'h1)
         begin
            csr_q[FSPC_WRT_BIT] <= 1'b0;  // RULE_22
            csr_q[FSPC_ERS_BIT] <= 1'b0;
            csr_q[FSPC_EN_BIT] <= 1'b0;
         end
         // programming countdown
         if (prog_active)
            prog_q <= prog_q - 32'h1;
         // software write to control/status
         if (csr_wr)
         begin
            // interrupt enable is always writable
            csr_q[FSPC_IRQEN_BIT] <= pwdata[FSPC_IRQEN_BIT];
            // no new command while flash busy
            if (cmd_ok && !prog_active && !csr_q[FSPC_EN_BIT])
            begin
               csr_q[4:0] <= pwdata[4:0];
               csr_q[FSPC_SIG_BIT] <= pwdata[FSPC_SIG_BIT];
               win_q <= 3'(FSPC_STORE_WIN);  // RULE_20
               if (pwdata[FSPC_SIG_BIT])
                  sig_win_q <= 3'(FSPC_LOAD_WIN);  // RULE_17
            end
         end
         // store instruction inside the armed window
         else if (store_go && win_q != 3'h0 && !prog_active)
         begin
            win_q <= 3'h0;
            // signature armed: no program op, but the buffer fill still runs
            if (csr_q[FSPC_SIG_BIT])
            begin
               csr_q[4:0] <= 5'h00;  // RULE_18
               op_q <= FSPC_OP_NOP;
            end
            // re-enable the readable region
            else if (csr_q[FSPC_REEN_BIT])
            begin
               csr_q[4:0] <= 5'h00;  // RULE_21
               // busy clears; no other branch sets it in the same cycle
               csr_q[FSPC_BUSY_BIT] <= 1'b0;  // RULE_15
               op_q <= FSPC_OP_REEN;
            end
            // erase or write the addressed page
            else if (csr_q[FSPC_WRT_BIT] || csr_q[FSPC_ERS_BIT])
            begin
               prog_q <= 32'(PROG_CYC);
               prog_halting_write_region_q <= !in_rww;  // RULE_22
               if (in_rww)
                  csr_q[FSPC_BUSY_BIT] <= 1'b1;  // RULE_13
               op_q <= csr_q[FSPC_WRT_BIT] ? FSPC_OP_WRITE : FSPC_OP_ERASE;
            end
            // bare enable: store fills the buffer
            else
            begin
               csr_q[FSPC_EN_BIT] <= 1'b0;
               csr_q[FSPC_BUSY_BIT] <= 1'b0;  // RULE_16
               op_q <= FSPC_OP_FILL;  // RULE_20
            end
         end
      end
   end

   // pointer, data and fuse registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ptr_q <= 16'h0000;
         data_q <= 16'h0000;
         boot_size_q <= 2'b00;
      end
      else if (wr)
      begin
         // word pointer, bit zero picks the load byte
         if (paddr == FSPC_PTR_OFF)
            ptr_q <= pwdata[15:0];
         // word for the next buffer fill
         if (paddr == FSPC_DATA_OFF)
            data_q <= pwdata[15:0];
         // fuse setting rides on every core write
         if (cfg_wr)
            boot_size_q <= pwdata[1:0];
      end
   end

   // temporary buffer fill, word from pointer
   always_ff @(posedge pclk)
   begin
      if (clk_en && store_go && win_q != 3'h0 && !prog_active
          && csr_q[4:0] == FSPC_CMD_FILL)
      begin
         // r0 to the even byte, r1 to the odd byte
         tmp_buf[{word_idx, 1'b0}] <= data_q[7:0];  // RULE_08
         tmp_buf[{word_idx, 1'b1}] <= data_q[15:8];
      end
   end

   // load instruction result byte
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rdat_q <= 8'h00;
      else if (load_go)
      begin
         // signature window: buffer stands in for the row
         if (sig_win_q != 3'h0)
            rdat_q <= tmp_buf[{7'h00, ptr_q[0]}];  // RULE_17
         // no read of the readable region while it is busy
         else if (!(csr_q[FSPC_BUSY_BIT] && in_rww))
            rdat_q <= ptr_q[0] ? flash_word[15:8]
                               : flash_word[7:0];  // RULE_11 RULE_14
      end
   end

   // read mux
   always_comb
   begin
      rd_d = 32'h0;
      // unmapped offsets read as zero
      case (paddr)
         FSPC_CSR_OFF: rd_d = {24'h0, csr_q};
         FSPC_PTR_OFF: rd_d = {16'h0, ptr_q};
         FSPC_DATA_OFF: rd_d = {16'h0, data_q};
         FSPC_CFG_OFF: rd_d = {30'h0, boot_size_q};
         FSPC_STAT_OFF: rd_d = {1'b0, boot_start, 1'b0, app_end};
         FSPC_RDAT_OFF: rd_d = {13'h0, op_q, page_num, rdat_q};
         FSPC_OP_OFF: rd_d = {9'h0, word_idx, 1'b0, word_addr};
         default: rd_d = 32'h0;
      endcase
   end

   // registered bus and status outputs
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         store_ready_irq <= 1'b0;
         core_halt <= 1'b0;
         rww_blocked <= 1'b0;
         flash_busy <= 1'b0;
      end
      else if (clk_en)
      begin
         // one-cycle ready after every setup cycle
         pready <= psel && !penable;
         // error on unmapped or misaligned offsets
         pslverr <= psel && !penable && (paddr > FSPC_OP_OFF
                    || paddr[1:0] != 2'b00);
         // read data captured at setup, stands until the next
         if (psel && !penable)
            prdata <= rd_d;
         // ready interrupt while no store is armed
         store_ready_irq <= csr_q[FSPC_IRQEN_BIT] && global_irq_en
                            && !csr_q[FSPC_EN_BIT];  // RULE_12
         // core stalls while the halting region programs
         core_halt <= prog_active && prog_halting_write_region_q;  // RULE_22
         rww_blocked <= csr_q[FSPC_BUSY_BIT];  // RULE_14
         flash_busy <= prog_active;
      end
   end
endmodule
`default_nettype wire

// ### test/fspc_ctrl_sva.sv
`default_nettype none
module fspc_ctrl_sva
#(
   parameter int PROG_CYC = 8
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic global_irq_en,
   input wire logic store_ready_irq,
   input wire logic core_halt,
   input wire logic rww_blocked,
   input wire logic flash_busy
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned busy_cnt_q; // length of current busy spell
   // count consecutive busy cycles
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         busy_cnt_q <= 0;
      else
         busy_cnt_q <= flash_busy ? busy_cnt_q + 1 : 0;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   busy_len_a: assert property (busy_cnt_q <= PROG_CYC + 2)
      else $error("programming ran too long");
   halt_busy_a: assert property (core_halt |-> flash_busy)
      else $error("halt without programming");
   irq_idle_a: assert property (store_ready_irq |-> !flash_busy)
      else $error("ready irq while programming");
   irq_gie_a: assert property
      (!global_irq_en && clk_en |=> !store_ready_irq)
      else $error("ready irq without global enable");
   blk_start_a: assert property ($rose(rww_blocked) |-> flash_busy)
      else $error("busy flag set without programming");
   blk_hold_a: assert property
      (rww_blocked && !psel && !$past(psel) |=> rww_blocked)
      else $error("busy flag cleared without access");
   reen_idle_a: assert property
      ($fell(rww_blocked) |-> !$past(flash_busy))
      else $error("region reenabled while flash busy");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   ready_ans_a: assert property (psel && !penable && clk_en |=> pready)
      else $error("no answer after setup");
   err_pair_a: assert property (pslverr |-> pready)
      else $error("error without ready");
endmodule
bind fspc_ctrl fspc_ctrl_sva #(.PROG_CYC(PROG_CYC)) u_sva (.pclk(pclk),
   .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .global_irq_en(global_irq_en),
   .store_ready_irq(store_ready_irq), .core_halt(core_halt),
   .rww_blocked(rww_blocked), .flash_busy(flash_busy));
`default_nettype wire

// ### test/fspc_core_model.sv
`default_nettype none
// processor core: interrupt flag and flash word fetch
module fspc_core_model
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic irq_on,
   input wire logic [14:0] word_addr,
   input wire logic core_halt,
   output logic global_irq_en,
   output logic [15:0] flash_word
);
   timeunit 1ns;
   timeprecision 1ps;
   // a halted core freezes; it never arms a signature read itself
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         global_irq_en <= 1'b0;
         flash_word <= 16'h0000;
      end
      else if (!core_halt)
      begin
         global_irq_en <= irq_on;
         flash_word <= {word_addr[7:0] ^ 8'h5A, word_addr[14:7]};
      end
   end
endmodule
`default_nettype wire

// ### test/fspc_ctrl_tb.sv
`default_nettype none
module fspc_ctrl_tb;
   import fspc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PCYC = 40;
   localparam logic [32:0] FULL = {33{1'b1}};
   logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
   logic irq_on, gie, irq, halt, blk, busy;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] fword, ptr, w;
   logic [14:0] maddr;
   logic [32:0] q_exp[$], q_msk[$]; // expected reads and masks
   int num_errors, n_checks;
   logic [14:0] boot [4] = '{15'h7000, 15'h7800, 15'h7C00, 15'h7E00};
   logic [7:0] cmds [5] = '{8'h01, 8'h03, 8'h05, 8'h11, 8'h21};
   fspc_ctrl #(.PC_W(15), .PROG_CYC(PCYC)) dut (.pclk(pclk),
      .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .global_irq_en(gie),
      .flash_word(fword), .store_ready_irq(irq), .core_halt(halt),
      .rww_blocked(blk), .flash_busy(busy));
   fspc_core_model core (.pclk(pclk), .presetn(presetn), .irq_on(irq_on),
      .word_addr(maddr), .core_halt(halt), .global_irq_en(gie),
      .flash_word(fword));
   // clock
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic chk(input logic [32:0] g, e, m);
      n_checks++;
      if ((g & m) !== (e & m))
      begin
         num_errors++;
         $display("wrong value at %0t: got %h exp %h", $time, g & m, e & m);
      end
   endtask
   // one apb transfer, request left up for a following setup
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
   endtask
   task automatic idle(input int n);
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (n) @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] e, m);
      q_exp.push_back(e);
      q_msk.push_back(m);
      apb(1'b0, a, 32'h0);
   endtask
   // csr write then store instruction inside the window
   task automatic cmd(input logic [7:0] c, input logic [31:0] cfg);
      apb(1'b1, FSPC_CSR_OFF, {24'h0, c});
      apb(1'b1, FSPC_CFG_OFF, cfg);
      idle(2);
   endtask
   task automatic wait_done();
      int k;
      k = 0;
      while (busy === 1'b1 && k < 100)
      begin
         @(posedge pclk);
         k++;
      end
      chk({32'h0, busy}, 33'h0, FULL);
   endtask
   task automatic end_sim();
      // a read note never answered counts as a mismatch
      if (q_exp.size() != 0)
         num_errors++;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // read results against the oldest note
   always @(posedge pclk)
      if (psel && penable && pready && !pwrite && q_exp.size() > 0)
         chk({pslverr, prdata}, q_exp.pop_front(), q_msk.pop_front());
   // watchdog
   initial
   begin
      repeat (5000) @(posedge pclk);
      num_errors++;
      end_sim();
   end
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {clk_en, irq_on, maddr, ptr, presetn} = {1'b1, 33'h0};
      void'($urandom(32'hd0e3c090));
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(FSPC_CSR_OFF, {25'h0, FSPC_CSR_RST}, FULL);
      rd(12'h01C, 33'h100000000, 33'h100000000);
      idle(1);
      chk({29'h0, irq, halt, blk, busy}, 33'h0, FULL);
      $display("test reset done");
      for (int f = 0; f < 4; f++)
      begin
         apb(1'b1, FSPC_CFG_OFF, 32'(f));
         rd(FSPC_STAT_OFF,
            {2'b0, boot[f], 1'b0, boot[f] - 15'h1}, FULL);
      end
      apb(1'b1, FSPC_CFG_OFF, 32'h0);
      $display("test decode done");
      repeat (3)
      begin
         ptr = 16'($urandom_range(16'hDFFE)) & 16'hFFFE;
         apb(1'b1, FSPC_PTR_OFF, {16'h0, ptr});
         apb(1'b1, FSPC_DATA_OFF, $urandom());
         cmd(8'h01, 32'h100);
         rd(FSPC_OP_OFF, {10'h0, ptr[7:1], 1'b0, ptr[15:1]}, FULL);
         rd(FSPC_RDAT_OFF, {14'h0, FSPC_OP_FILL, 16'h0},
            33'h100070000);
      end
      $display("test fill done");
      apb(1'b1, FSPC_PTR_OFF, 32'h1200);
      cmd(8'h03, 32'h100);
      chk({31'h0, halt, blk}, 33'h1, FULL);
      cmd(8'h11, 32'h100);
      rd(FSPC_CSR_OFF, 33'h40, 33'h40);
      rd(FSPC_RDAT_OFF, {14'h0, FSPC_OP_ERASE, 16'h1200},
         33'h10007FF00);
      wait_done();
      chk({32'h0, blk}, 33'h1, FULL);
      cmd(8'h11, 32'h100);
      chk({32'h0, blk}, 33'h0, FULL);
      cmd(8'h03, 32'h100);
      wait_done();
      cmd(8'h01, 32'h100);
      chk({32'h0, blk}, 33'h0, FULL);
      apb(1'b1, FSPC_PTR_OFF, 32'hF000);
      cmd(8'h05, 32'h100);
      chk({31'h0, halt, blk}, 33'h2, FULL);
      wait_done();
      chk({32'h0, halt}, 33'h0, FULL);
      $display("test program done");
      irq_on <= 1'b1;
      apb(1'b1, FSPC_CSR_OFF, 32'h80);
      idle(3);
      chk({32'h0, irq}, 33'h1, FULL);
      apb(1'b1, FSPC_CSR_OFF, 32'h81);
      idle(2);
      chk({32'h0, irq}, 33'h0, FULL);
      idle(6);
      chk({32'h0, irq}, 33'h1, FULL);
      irq_on <= 1'b0;
      idle(3);
      chk({32'h0, irq}, 33'h0, FULL);
      $display("test irq done");
      foreach (cmds[i])
      begin
         apb(1'b1, FSPC_CSR_OFF, {24'h0, cmds[i]});
         idle(6);
         rd(FSPC_CSR_OFF, 33'h0, 33'h3F);
      end
      apb(1'b1, FSPC_CSR_OFF, 32'h07);
      rd(FSPC_CSR_OFF, 33'h0, 33'h3F);
      $display("test window done");
      for (int z = 0; z < 2; z++)
      begin
         ptr = 16'h0A40 | 16'(z);
         w = {ptr[8:1] ^ 8'h5A, ptr[15:8]};
         maddr <= ptr[15:1];
         apb(1'b1, FSPC_PTR_OFF, {16'h0, ptr});
         apb(1'b1, FSPC_CFG_OFF, 32'h200);
         idle(2);
         rd(FSPC_RDAT_OFF, {25'h0, z ? w[15:8] : w[7:0]},
            33'h1000000FF);
      end
      cmd(8'h21, 32'h100);
      rd(FSPC_RDAT_OFF, {14'h0, FSPC_OP_NOP, 16'h0}, 33'h100070000);
      idle(2);
      $display("test load done");
      end_sim();
   end
endmodule
`default_nettype wire
